// ### shared/psa_pkg.sv
package psa_pkg;
   // Array geometry
   localparam int ADDR_W = 18;
   localparam int LANES = 2;
   localparam int LANE_DATA_W = 8;
   localparam int LANE_W = LANE_DATA_W + 1;
   localparam int DATA_W = LANES * LANE_DATA_W;
   localparam int WORD_W = LANES * LANE_W;
   // Burst counter field: the two lowest address bits
   localparam int BURST_W = 2;
   localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
   // Sleep entry and exit, in clock cycles
   localparam int SLEEP_CYCLES = 2;
   localparam logic [1:0] SLEEP_LAST = 2'(SLEEP_CYCLES - 1);
   // Write buffer shape
   localparam int FIFO_DEPTH = 16;
   // Reset values
   localparam logic [BURST_W-1:0] BURST_RST = 2'h0;

   // A captured write beat on its way into the array
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0] lane_en;
      logic [WORD_W-1:0] word;
   } psa_wr_entry_t;

   // Sleep sequencing
   typedef enum logic [1:0] {
      SL_AWAKE = 2'b00,
      SL_ENTER = 2'b01,
      SL_ASLEEP = 2'b10,
      SL_EXIT = 2'b11
   } psa_sleep_t;
endpackage

// ### src/psa_core.sv
// Functional notes
// - Qualifier high: the edge is ignored, burst and pipeline state hold; sleep sequencing and buffer drain go on.
// - Selected, qualified, load, strobe high: read starts, address latched.
// - Read data leaves the output register after the next edge, if drive enabled.
// - A new command is accepted the cycle right after a read.
// - Deselect tri-states the outputs only after the following edge.
// - Burst counter on two low address bits, four beats, wraps.
// - Strap low gives linear order, high gives interleaved order.
// - Advance high increments the counter, selects and strobe ignored.
// - Direction captured at load, kept for the whole burst.
// - Selected, qualified, strobe low: write starts, address and controls latched.
// - Edge after a write command: outputs tri-stated whatever the drive enable.
// - Write data captured at second edge after the command.
// - Only lanes with asserted lane strobe are written.
// - After first read clock, drivers follow drive enable and internal control.
// - Sleep request enters low-power sleep, two cycles in, two out.
// - Accesses in flight at sleep entry are dropped as invalid; a write already in stage two still has its data captured and written.
// - Linear: start plus beat count, modulo four.
// - Interleaved: start XOR beat count.
// - Selected only when select one low, two high, three low.
// - Comes up deselected with outputs off regardless of drive enable.

// Write buffer between the capture stage and the array
module psa_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [DEPTH];
   logic [PW-1:0] wr_ptr_reg;
   logic [PW-1:0] rd_ptr_reg;
   logic [PW:0] fill_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // Honest flags from the fill count
   assign in_ready = fill_reg != (PW + 1)'(DEPTH);
   assign out_valid = fill_reg != '0;
   assign out_data = store[rd_ptr_reg];

   // Pointers and count
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         fill_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         fill_reg <= fill_reg + (PW + 1)'(push) - (PW + 1)'(pop);
      end
   end

   // Storage has no reset; only written words are ever read
   always_ff @(posedge ref_clk) begin
      if (push) store[wr_ptr_reg] <= in_data;
   end
endmodule

module psa_core #(
   parameter int AW = psa_pkg::ADDR_W,
   parameter int FIFO_DEPTH = psa_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // Synchronous command inputs
   input wire logic clock_qualifier_n,
   input wire logic advance_or_load,
   input wire logic write_strobe_n,
   input wire logic select_one_n,
   input wire logic select_two,
   input wire logic select_three_n,
   input wire logic [psa_pkg::LANES-1:0] byte_lane_write_n,
   input wire logic [AW-1:0] address,
   // Asynchronous inputs and strap
   input wire logic output_drive_n,
   input wire logic sleep_request,
   input wire logic mode,
   // Data lines, split into input, output and enable
   input wire logic [psa_pkg::DATA_W-1:0] data_lines_in,
   output logic [psa_pkg::DATA_W-1:0] data_lines_out,
   output logic data_lines_oe,
   input wire logic [psa_pkg::LANES-1:0] parity_lines_in,
   output logic [psa_pkg::LANES-1:0] parity_lines_out,
   output logic parity_lines_oe,
   // Status
   output logic accept_ready,
   output logic sleeping
);
   import psa_pkg::*;

   logic [WORD_W-1:0] mem [2**AW];

   // Two-flop synchronisers for the asynchronous inputs
   logic [1:0] drive_n_sync_reg;
   logic [1:0] sleep_sync_reg;
   logic [1:0] mode_sync_reg;
   always_ff @(posedge ref_clk) begin
      drive_n_sync_reg <= {drive_n_sync_reg[0], output_drive_n};
      sleep_sync_reg <= {sleep_sync_reg[0], sleep_request};
      mode_sync_reg <= {mode_sync_reg[0], mode};
   end
   wire drive_n_s = drive_n_sync_reg[1];
   wire sleep_s = sleep_sync_reg[1];
   wire interleave = mode_sync_reg[1];

   // Sleep sequencer state
   psa_sleep_t sleep_reg, sleep_next;
   logic [1:0] sleep_cnt_reg;
   wire awake = sleep_reg == SL_AWAKE;

   // Burst and command state
   logic active_reg;
   logic dir_write_reg;
   logic [AW-1:0] base_reg;
   logic [BURST_W-1:0] start_reg;
   logic [BURST_W-1:0] cnt_reg;
   // Stage one: the address phase that was just accepted
   logic s1_valid_reg;
   logic s1_write_reg;
   logic [AW-1:0] s1_addr_reg;
   logic [LANES-1:0] s1_lane_reg;
   // Stage two: write waiting for its data edge
   logic s2_valid_reg;
   logic [AW-1:0] s2_addr_reg;
   logic [LANES-1:0] s2_lane_reg;
   // Output register
   logic out_valid_reg;
   logic [WORD_W-1:0] out_word_reg;

   // A full write buffer stalls the pipeline just like a high qualifier
   wire fifo_in_ready;
   wire en = !clock_qualifier_n && fifo_in_ready;
   wire load = !advance_or_load;
   wire selected = !select_one_n && select_two && !select_three_n;
   wire cmd_ok = en && awake;
   wire start_rd = cmd_ok && load && selected && write_strobe_n;
   wire start_wr = cmd_ok && load && selected && !write_strobe_n;
   wire deselect = cmd_ok && load && !selected;
   wire advance = cmd_ok && !load && active_reg;

   // linear or interleaved order, picked by the strap, wraps within two bits
   wire [BURST_W-1:0] cnt_step = cnt_reg + BURST_ONE;
   wire [BURST_W-1:0] lin_low = start_reg + cnt_step;
   wire [BURST_W-1:0] ilv_low = start_reg ^ cnt_step;
   wire [BURST_W-1:0] next_low = interleave ? ilv_low : lin_low;
   wire [AW-1:0] adv_addr = {base_reg[AW-1:BURST_W], next_low};

   // Burst counter and latched direction
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         active_reg <= 1'b0;
         dir_write_reg <= 1'b0;
         base_reg <= '0;
         start_reg <= BURST_RST;
         cnt_reg <= BURST_RST;
      end else if (!awake) begin
         active_reg <= 1'b0;
      end else if (cmd_ok && load) begin
         active_reg <= selected;
         dir_write_reg <= !write_strobe_n;
         base_reg <= address;
         start_reg <= address[BURST_W-1:0];
         cnt_reg <= BURST_RST;
      end else if (advance) begin
         cnt_reg <= cnt_step;
      end
   end

   // Address stage
   always_ff @(posedge ref_clk) begin
      if (rst || !awake) begin
         s1_valid_reg <= 1'b0;
         s1_write_reg <= 1'b0;
         s1_addr_reg <= '0;
         s1_lane_reg <= '0;
      end else if (en) begin
         // a command is taken every qualified cycle
         s1_valid_reg <= start_rd || start_wr || advance;
         s1_write_reg <= load ? !write_strobe_n : dir_write_reg;
         s1_addr_reg <= load ? address : adv_addr;
         s1_lane_reg <= ~byte_lane_write_n;
      end
   end

   // Read data and write hand-off
   wire s1_read = s1_valid_reg && !s1_write_reg;
   wire array_read = en && s1_read;
   always_ff @(posedge ref_clk) begin
      if (rst || !awake) begin
         out_valid_reg <= 1'b0;
         s2_valid_reg <= 1'b0;
         s2_addr_reg <= '0;
         s2_lane_reg <= '0;
      end else if (en) begin
         out_valid_reg <= s1_read;
         s2_valid_reg <= s1_valid_reg && s1_write_reg;
         s2_addr_reg <= s1_addr_reg;
         s2_lane_reg <= s1_lane_reg;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (array_read) out_word_reg <= mem[s1_addr_reg];
   end

   // Output drive: data register gated by drive enable and pipeline state
   wire [WORD_W-1:0] out_word = out_word_reg;
   genvar g;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane_out
         assign data_lines_out[g*LANE_DATA_W +: LANE_DATA_W] =
            out_word[g*LANE_W +: LANE_DATA_W];
         assign parity_lines_out[g] = out_word[g*LANE_W + LANE_DATA_W];
      end
   endgenerate
   // drive enable combined with internal control
   assign data_lines_oe = out_valid_reg && !drive_n_s && awake;
   assign parity_lines_oe = data_lines_oe;

   // write data captured two edges after the command
   psa_wr_entry_t cap_entry;
   wire cap_push = en && s2_valid_reg;
   generate
      for (g = 0; g < LANES; g++) begin : g_lane_in
         assign cap_entry.word[g*LANE_W +: LANE_W] =
            {parity_lines_in[g], data_lines_in[g*LANE_DATA_W +: LANE_DATA_W]};
      end
   endgenerate
   assign cap_entry.addr = s2_addr_reg;
   assign cap_entry.lane_en = s2_lane_reg;

   // Buffer drains into the array when the port is not reading and the core is not in SL_ASLEEP
   psa_wr_entry_t drain_entry;
   wire drain_valid;
   wire drain_ready = !array_read && sleep_reg != SL_ASLEEP;
   psa_fifo #(
      .WIDTH($bits(psa_wr_entry_t)),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_valid(cap_push),
      .in_ready(fifo_in_ready),
      .in_data(cap_entry),
      .out_valid(drain_valid),
      .out_ready(drain_ready),
      .out_data(drain_entry)
   );
   assign accept_ready = fifo_in_ready;

   always_ff @(posedge ref_clk) begin
      if (drain_valid && drain_ready) begin
         for (int i = 0; i < LANES; i++) begin
            if (drain_entry.lane_en[i])
               mem[drain_entry.addr][i*LANE_W +: LANE_W] <=
                  drain_entry.word[i*LANE_W +: LANE_W];
         end
      end
   end

   // sleep sequencing, two cycles each way
   wire sleep_done = sleep_cnt_reg == SLEEP_LAST;
   always_comb begin
      sleep_next = sleep_reg;
      case (sleep_reg)
         SL_AWAKE: if (sleep_s) sleep_next = SL_ENTER;
         SL_ENTER: if (sleep_done) sleep_next = SL_ASLEEP;
         SL_ASLEEP: if (!sleep_s) sleep_next = SL_EXIT;
         SL_EXIT: if (sleep_done) sleep_next = SL_AWAKE;
         default: sleep_next = SL_AWAKE;
      endcase
   end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sleep_reg <= SL_AWAKE;
         sleep_cnt_reg <= 2'h0;
      end else begin
         sleep_reg <= sleep_next;
         sleep_cnt_reg <= (sleep_next != sleep_reg) ? 2'h0 : sleep_cnt_reg + 2'h1;
      end
   end
   assign sleeping = !awake;

   // Checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   qual_hold_a: assert property (
      clock_qualifier_n && awake && !$past(rst) |=> $stable(cnt_reg) && $stable(base_reg))
      else $error("state moved on an unqualified edge");
   read_launch_a: assert property (
      start_rd && fifo_in_ready |=> s1_valid_reg && !s1_write_reg && s1_addr_reg == $past(address))
      else $error("read not launched");
   read_out_a: assert property (
      start_rd ##1 (en && awake && !drive_n_s) ##1 (awake && !drive_n_s) |-> data_lines_oe)
      else $error("read data not driven");
   deselect_pipe_a: assert property (
      deselect ##1 (en && awake) |=> !data_lines_oe)
      else $error("deselect did not tri-state");
   write_tristate_a: assert property (
      start_wr ##1 en |=> !data_lines_oe && !parity_lines_oe)
      else $error("outputs on after write command");
   write_capture_a: assert property (
      start_wr ##1 (en && awake) ##1 (en && awake) |-> cap_push)
      else $error("write data not captured");
   burst_wrap_a: assert property (
      advance |=> cnt_reg == $past(cnt_reg) + BURST_ONE)
      else $error("burst counter did not step");
   interleave_addr_a: assert property (
      advance && interleave && en |=> s1_addr_reg[1:0] == ($past(start_reg) ^ cnt_reg))
      else $error("interleaved beat address wrong");
   burst_dir_a: assert property (
      advance |=> s1_write_reg == $past(dir_write_reg))
      else $error("burst direction changed");
   sleep_entry_a: assert property (
      awake && sleep_s |=> (sleep_reg == SL_ENTER) [*2] ##1 (sleep_reg == SL_ASLEEP))
      else $error("sleep entry not two cycles");
   sleep_flush_a: assert property (
      sleep_reg == SL_ENTER |=> !s1_valid_reg && !s2_valid_reg && !data_lines_oe)
      else $error("access survived sleep entry");
endmodule

// ### testbench/psa_ctl_model.sv
// Memory controller on the far side of the synchronous bus
module psa_ctl_model (
   // Command lines
   output logic clock_qualifier_n,
   output logic advance_or_load,
   output logic write_strobe_n,
   output logic select_one_n,
   output logic select_two,
   output logic select_three_n,
   output logic [psa_pkg::LANES-1:0] byte_lane_write_n,
   output logic [psa_pkg::ADDR_W-1:0] address,
   // Shared data bus
   input wire logic [psa_pkg::WORD_W-1:0] dev_word,
   input wire logic dev_oe,
   output logic [psa_pkg::WORD_W-1:0] bus_word
);
   import psa_pkg::*;
   logic drv_on = 1'b0;
   logic [WORD_W-1:0] drv_val = '0;
   // no bus fight
   // Released bus shows the inverse of the last value, so a stale capture is caught
   assign bus_word = dev_oe ? dev_word : (drv_on ? drv_val : ~drv_val);
   // command encoding
   // Kinds: 0 deselect, 1 read, 2 write, 3 advance, 4 stall
   // Advances show selects off and strobe low on purpose: the device must ignore both
   task automatic put(input int kind, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln);
      clock_qualifier_n = (kind == 4);
      advance_or_load = (kind == 3);
      write_strobe_n = !(kind == 2 || kind == 3);
      {select_one_n, select_two, select_three_n} = (kind == 1 || kind == 2) ? 3'h2 : 3'h5;
      byte_lane_write_n = ln;
      address = a;
   endtask
   task automatic give(input logic on, input logic [WORD_W-1:0] v);
      drv_on = on;
      if (on) begin
         drv_val = v;
      end
   endtask
endmodule

// ### testbench/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import psa_pkg::*;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic output_drive_n = 1'b0;
   logic sleep_request = 1'b0;
   logic mode = 1'b0;
   logic cq_n, adv, ws_n, s1_n, s2, s3_n, d_oe, p_oe, acc_rdy, sleeping;
   logic [LANES-1:0] ln_n, p_in, p_out;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] d_in, d_out;
   logic [WORD_W-1:0] bus_w;
   int mismatches = 0;
   int cmp_count = 0;
   logic drv_exp = 1'b1;
   logic [WORD_W-1:0] salt = 18'h2a5a5;
   logic [WORD_W-1:0] mem_exp [logic [ADDR_W-1:0]];
   // Commands two and one qualified edges back
   int st_k [2] = '{0, 0};
   logic [ADDR_W-1:0] st_a [2];
   logic [LANES-1:0] st_l [2];
   int b_dir = 0;
   logic [ADDR_W-1:0] b_base = '0;
   logic [1:0] b_k = '0;

   // Clock and bus split
   always #2ns ref_clk = ~ref_clk;
   assign {p_in, d_in} = bus_w;

   psa_core dut_u (.ref_clk(ref_clk), .rst(rst), .clock_qualifier_n(cq_n),
      .advance_or_load(adv), .write_strobe_n(ws_n), .select_one_n(s1_n), .select_two(s2),
      .select_three_n(s3_n), .byte_lane_write_n(ln_n), .address(addr),
      .output_drive_n(output_drive_n), .sleep_request(sleep_request), .mode(mode),
      .data_lines_in(d_in), .data_lines_out(d_out), .data_lines_oe(d_oe),
      .parity_lines_in(p_in), .parity_lines_out(p_out), .parity_lines_oe(p_oe),
      .accept_ready(acc_rdy), .sleeping(sleeping));
   psa_ctl_model ctl_u (.clock_qualifier_n(cq_n), .advance_or_load(adv), .write_strobe_n(ws_n),
      .select_one_n(s1_n), .select_two(s2), .select_three_n(s3_n), .byte_lane_write_n(ln_n),
      .address(addr), .dev_word({p_out, d_out}), .dev_oe(d_oe), .bus_word(bus_w));

   // Comparisons
   task automatic check_bit(input string what, input logic exp, input logic got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic check_word(input string what, input logic [WORD_W-1:0] exp,
                             input logic [WORD_W-1:0] got);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // One bus cycle: settle the result of two edges back, then issue a command
   task automatic cyc(input int kind, input logic [ADDR_W-1:0] a, input logic [LANES-1:0] ln);
      int k;
      logic [ADDR_W-1:0] ea;
      logic [WORD_W-1:0] w;
      logic [WORD_W-1:0] m;
      logic e;
      k = kind;
      ea = a;
      @(negedge ref_clk);
      e = (st_k[1] == 1) && drv_exp;
      check_bit("data oe", e, d_oe);
      check_bit("parity oe", e, p_oe);
      check_bit("accept ready", 1'b1, acc_rdy);
      if (e) begin
         check_word("read word", mem_exp[st_a[1]], {p_out, d_out});
      end
      w = salt ^ 18'(st_a[1] * 18'h0b5);
      ctl_u.give(st_k[1] == 2, w);
      if (st_k[1] == 2) begin
         m = mem_exp.exists(st_a[1]) ? mem_exp[st_a[1]] : '0;
         for (int i = 0; i < LANES; i++) begin
            if (!st_l[1][i]) begin
               m[8*i +: 8] = w[8*i +: 8];
               m[DATA_W+i] = w[DATA_W+i];
            end
         end
         mem_exp[st_a[1]] = m;
      end
      // Burst address: linear adds, interleaved XORs, both wrap in two bits
      if (k == 1 || k == 2) begin
         b_base = a;
         b_k = '0;
         b_dir = k;
      end else if (k == 3) begin
         b_k = b_k + 2'h1;
         ea = {b_base[ADDR_W-1:2], mode ? b_base[1:0] ^ b_k : b_base[1:0] + b_k};
         k = b_dir;
      end else if (k == 0) begin
         b_dir = 0;
      end
      ctl_u.put(kind, a, ln);
      if (kind != 4) begin
         st_k[1] = st_k[0];
         st_a[1] = st_a[0];
         st_l[1] = st_l[0];
         st_k[0] = k;
         st_a[0] = ea;
         st_l[0] = ln;
      end
      @(posedge ref_clk);
   endtask
   task automatic idle(input int n);
      repeat (n) cyc(0, '0, 2'h3);
   endtask
   task automatic rd4();
      for (int i = 0; i < 4; i++) cyc(1, 18'h100 + 18'(i), 2'h3);
   endtask
   task automatic wait_sleep(input logic lvl);
      for (int n = 0; n < 8 && sleeping !== lvl; n++) begin
         cyc(0, '0, 2'h3);
         #1;
      end
      check_bit("sleeping", lvl, sleeping);
      if (sleeping !== lvl) close_out();
   endtask

   // Main sequence
   initial begin
      int n;
      int i;
      ctl_u.put(0, '0, 2'h3);
      repeat (8) @(negedge ref_clk);
      rst = 1'b0;
      check_bit("oe at reset", 1'b0, d_oe);
      idle(3);
      for (i = 0; i < 4; i++) cyc(2, 18'h100 + 18'(i), 2'h0);
      idle(4);
      rd4();
      cyc(2, 18'h104, 2'h0);
      cyc(1, 18'h100, 2'h3);
      cyc(0, '0, 2'h3);
      cyc(3, '0, 2'h3);
      idle(4);
      salt = 18'h1c3e7;
      for (i = 1; i < 4; i++) cyc(2, 18'h100 + 18'(i), 2'(i));
      idle(4);
      rd4();
      salt = 18'h0f0f3;
      cyc(2, 18'h101, 2'h0);
      cyc(3, '0, 2'h1);
      cyc(4, '0, 2'h1);
      cyc(3, '0, 2'h0);
      cyc(3, '0, 2'h2);
      idle(4);
      for (int md = 0; md < 2; md++) begin
         @(negedge ref_clk);
         mode = md[0];
         idle(4);
         cyc(1, 18'h101, 2'h3);
         cyc(3, '0, 2'h3);
         cyc(4, '0, 2'h3);
         repeat (4) cyc(3, '0, 2'h3);
         idle(2);
      end
      @(negedge ref_clk);
      output_drive_n = 1'b1;
      idle(3);
      drv_exp = 1'b0;
      cyc(1, 18'h100, 2'h3);
      idle(2);
      @(negedge ref_clk);
      output_drive_n = 1'b0;
      drv_exp = 1'b1;
      idle(3);
      @(negedge ref_clk);
      sleep_request = 1'b1;
      wait_sleep(1'b1);
      idle(3);
      @(negedge ref_clk);
      sleep_request = 1'b0;
      wait_sleep(1'b0);
      idle(2);
      rd4();
      idle(2);
      // Writes between reads: the buffer only drains on edges without an array read
      for (n = 0; n < 8; n++) begin
         cyc(2, 18'h200 + 18'(n), 2'h0);
         cyc(1, 18'h100 + 18'(n % 4), 2'h3);
      end
      idle(4);
      // Buffered words must reach the array intact and in order
      for (n = 0; n < 8; n++) cyc(1, 18'h200 + 18'(n), 2'h3);
      idle(2);
      close_out();
   end
endmodule
